// ---- verilog/dpbw_pkg.sv ----
package dpbw_pkg;

  // ----------------------------------------
  // Sequencer timing, in clocks
  // ----------------------------------------
  localparam int CNT_W = 3;
  // First byte: data with select, strobe three clocks later
  localparam logic [CNT_W-1:0] SETUP_FIRST_LOAD = 3'h2;
  // Later bytes: strobe one clock after new data
  localparam logic [CNT_W-1:0] SETUP_NEXT_LOAD = 3'h0;
  // Strobe held low for five clocks
  localparam logic [CNT_W-1:0] STROBE_LOAD = 3'h4;
  // Two clocks from strobe negation to next byte
  localparam logic [CNT_W-1:0] RECOVER_LOAD = 3'h1;
  // Select held high two clocks before idle
  localparam logic [CNT_W-1:0] GAP_LOAD = 3'h1;
  localparam logic [CNT_W-1:0] CNT_ZERO = 3'h0;
  localparam logic [CNT_W-1:0] CNT_ONE = 3'h1;

  // ----------------------------------------
  // Pin widths and rest values
  // ----------------------------------------
  localparam int ADDR_W = 4;
  localparam int BYTE_W = 8;
  localparam logic [ADDR_W-1:0] ADDR_REST = 4'h0;
  localparam logic [BYTE_W-1:0] BYTE_REST = 8'h00;

  // ----------------------------------------
  // Sequencer states
  // ----------------------------------------
  typedef enum logic [4:0] {
    ST_IDLE    = 5'h01,
    ST_SETUP   = 5'h02,
    ST_STROBE  = 5'h04,
    ST_RECOVER = 5'h08,
    ST_GAP     = 5'h10
  } dpbw_state_t;

  // Drive toward the decoder link
  typedef struct packed {
    logic [ADDR_W-1:0] decoderRegAddress;
    logic addrOe;
    logic [BYTE_W-1:0] decoderByteBus;
    logic byteBusOe;
    logic portSelectN;
    logic byteWriteStrobeN;
  } dpbw_link_t;

  // Whole sequencer state
  typedef struct packed {
    dpbw_state_t state;
    logic [CNT_W-1:0] cnt;
    logic moreBytes;
    dpbw_link_t link;
    logic fifoPop;
    logic busBusy;
    logic reqS1;
    logic reqS2;
    logic ackS1;
    logic ackS2;
  } dpbw_st_t;

endpackage : dpbw_pkg

// ---- verilog/dpbw_burst_writer.sv ----
module dpbw_burst_writer (
  // Clock and reset
  input wire logic clock,
  input wire logic rst,
  // Configuration
  input wire logic requestPinMode,
  input wire logic readyCheckEn,
  input wire logic transferPauseBit,
  input wire logic [dpbw_pkg::ADDR_W-1:0] fifoRegAddr,
  // Host access sequencer
  input wire logic hostPending,
  input wire logic hostCycleActive,
  output logic busBusy,
  // Port FIFO, show-ahead
  input wire logic fifoValid,
  input wire logic [dpbw_pkg::BYTE_W-1:0] fifoByte,
  output logic fifoPop,
  // Decoder link pins
  input wire logic sharedPinIn,
  input wire logic targetAckIn,
  output logic [dpbw_pkg::ADDR_W-1:0] decoderRegAddress,
  output logic addrOe,
  output logic [dpbw_pkg::BYTE_W-1:0] decoderByteBus,
  output logic byteBusOe,
  output logic portSelectN,
  output logic byteWriteStrobeN
);

  // ----------------------------------------
  // State and reset value
  // ----------------------------------------
  localparam dpbw_pkg::dpbw_st_t ST_RST = '{
    state: dpbw_pkg::ST_IDLE,
    cnt: dpbw_pkg::CNT_ZERO,
    moreBytes: 1'b0,
    link: '{
      decoderRegAddress: dpbw_pkg::ADDR_REST,
      addrOe: 1'b0,
      decoderByteBus: dpbw_pkg::BYTE_REST,
      byteBusOe: 1'b0,
      portSelectN: 1'b1,
      byteWriteStrobeN: 1'b1
    },
    fifoPop: 1'b0,
    busBusy: 1'b0,
    reqS1: 1'b0,
    reqS2: 1'b0,
    ackS1: 1'b0,
    ackS2: 1'b0
  };

  dpbw_pkg::dpbw_st_t st_q;
  dpbw_pkg::dpbw_st_t st_d;
  logic reqSync;
  logic goOn;

  // Request only counts when the shared pin is in request mode
  assign reqSync = st_q.reqS2 & requestPinMode;
  // Continue test shared by start and per-byte check
  assign goOn = reqSync & ~transferPauseBit & ~hostPending
              & fifoValid;

  // ----------------------------------------
  // Next state
  // ----------------------------------------
  always_comb
  begin
    st_d = st_q;
    st_d.fifoPop = 1'b0;
    // Two flops per asynchronous input
    st_d.reqS1 = sharedPinIn;
    st_d.reqS2 = st_q.reqS1;
    st_d.ackS1 = targetAckIn;
    st_d.ackS2 = st_q.ackS1;
    case (st_q.state)
      dpbw_pkg::ST_IDLE:
      begin
        // Bus idle: no host cycle owns it
        if (!hostCycleActive && goOn)
        begin
          st_d.state = dpbw_pkg::ST_SETUP;
          st_d.cnt = dpbw_pkg::SETUP_FIRST_LOAD;
          st_d.link.decoderRegAddress = fifoRegAddr;
          st_d.link.addrOe = 1'b1;
          st_d.link.portSelectN = 1'b0;
          st_d.link.decoderByteBus = fifoByte;
          st_d.link.byteBusOe = 1'b1;
          st_d.fifoPop = 1'b1;
        end
      end
      dpbw_pkg::ST_SETUP:
      begin
        if (st_q.cnt != dpbw_pkg::CNT_ZERO)
        begin
          st_d.cnt = st_q.cnt - dpbw_pkg::CNT_ONE;
        end
        else
        begin
          st_d.state = dpbw_pkg::ST_STROBE;
          st_d.cnt = dpbw_pkg::STROBE_LOAD;
          st_d.link.byteWriteStrobeN = 1'b0;
        end
      end
      dpbw_pkg::ST_STROBE:
      begin
        if (st_q.cnt != dpbw_pkg::CNT_ZERO)
        begin
          st_d.cnt = st_q.cnt - dpbw_pkg::CNT_ONE;
        end
        // Wait states while ready is low in the variant
        else if (!readyCheckEn || st_q.ackS2)
        begin
          st_d.state = dpbw_pkg::ST_RECOVER;
          st_d.cnt = dpbw_pkg::RECOVER_LOAD;
          st_d.link.byteWriteStrobeN = 1'b1;
          st_d.moreBytes = goOn;
        end
      end
      dpbw_pkg::ST_RECOVER:
      begin
        if (st_q.cnt != dpbw_pkg::CNT_ZERO)
        begin
          st_d.cnt = st_q.cnt - dpbw_pkg::CNT_ONE;
        end
        else if (st_q.moreBytes)
        begin
          // Next byte, same address and select
          st_d.state = dpbw_pkg::ST_SETUP;
          st_d.cnt = dpbw_pkg::SETUP_NEXT_LOAD;
          st_d.link.decoderByteBus = fifoByte;
          st_d.fifoPop = 1'b1;
          st_d.moreBytes = 1'b0;
        end
        else
        begin
          // Release the link; host access may follow
          st_d.state = dpbw_pkg::ST_GAP;
          st_d.cnt = dpbw_pkg::GAP_LOAD;
          st_d.link.addrOe = 1'b0;
          st_d.link.decoderRegAddress = dpbw_pkg::ADDR_REST;
          st_d.link.byteBusOe = 1'b0;
          st_d.link.portSelectN = 1'b1;
        end
      end
      dpbw_pkg::ST_GAP:
      begin
        if (st_q.cnt != dpbw_pkg::CNT_ZERO)
        begin
          st_d.cnt = st_q.cnt - dpbw_pkg::CNT_ONE;
        end
        else
        begin
          st_d.state = dpbw_pkg::ST_IDLE;
        end
      end
      default:
      begin
        st_d = ST_RST;
      end
    endcase
    st_d.busBusy = (st_d.state != dpbw_pkg::ST_IDLE);
  end

  // ----------------------------------------
  // State register
  // ----------------------------------------
  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      st_q <= ST_RST;
    end
    else
    begin
      st_q <= st_d;
    end
  end

  // Outputs straight from the state register
  assign decoderRegAddress = st_q.link.decoderRegAddress;
  assign addrOe = st_q.link.addrOe;
  assign decoderByteBus = st_q.link.decoderByteBus;
  assign byteBusOe = st_q.link.byteBusOe;
  assign portSelectN = st_q.link.portSelectN;
  assign byteWriteStrobeN = st_q.link.byteWriteStrobeN;
  assign fifoPop = st_q.fifoPop;
  assign busBusy = st_q.busBusy;

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  a_reset_idle: assert property (@(posedge clock)
    rst |=> portSelectN && byteWriteStrobeN && !byteBusOe)
    else $error("port not idle after reset");
  a_sync_delay: assert property (@(posedge clock) disable iff (rst)
    !$past(rst, 2) |-> st_q.reqS2 == $past(sharedPinIn, 2))
    else $error("request sync delay wrong");
  a_start_cond: assert property (@(posedge clock) disable iff (rst)
    $fell(portSelectN) |-> $past(reqSync && !transferPauseBit
      && !hostPending && !hostCycleActive))
    else $error("burst started without conditions");
  a_first_data: assert property (@(posedge clock) disable iff (rst)
    $fell(portSelectN) |-> byteBusOe && addrOe ##3 !byteWriteStrobeN)
    else $error("first byte timing wrong");
  a_strobe_basic: assert property (@(posedge clock) disable iff (rst)
    $fell(byteWriteStrobeN) && !readyCheckEn |->
      !byteWriteStrobeN[*5] ##1 byteWriteStrobeN)
    else $error("strobe width not five clocks");
  a_strobe_ready: assert property (@(posedge clock) disable iff (rst)
    $rose(byteWriteStrobeN) |-> !$past(readyCheckEn) || $past(st_q.ackS2))
    else $error("strobe negated without ready");
  a_next_byte: assert property (@(posedge clock) disable iff (rst)
    $rose(byteWriteStrobeN) && $past(goOn) |->
      ##2 fifoPop && !portSelectN ##1 !byteWriteStrobeN)
    else $error("next byte timing wrong");
  a_pause_stop: assert property (@(posedge clock) disable iff (rst)
    $rose(byteWriteStrobeN) && $past(transferPauseBit || hostPending) |->
      !portSelectN ##2 portSelectN && !byteBusOe)
    else $error("burst did not stop on pause");
  a_sel_gap: assert property (@(posedge clock) disable iff (rst)
    $rose(portSelectN) |-> portSelectN[*2] ##1 !busBusy)
    else $error("select gap before idle wrong");
  a_addr_stable: assert property (@(posedge clock) disable iff (rst)
    !portSelectN && $past(!portSelectN) |-> $stable(decoderRegAddress))
    else $error("address changed inside burst");
  a_no_empty: assert property (@(posedge clock) disable iff (rst)
    fifoPop |-> $past(fifoValid))
    else $error("byte taken from empty fifo");

endmodule : dpbw_burst_writer

// ---- dv/dpbw_decoder_model.sv ----
// Decoder with a small byte FIFO behind one register
module dpbw_decoder_model #(
  parameter int DEPTH = 3
) (
  // Clock
  input wire logic clock,
  // Link from the port
  input wire logic portSelectN,
  input wire logic byteWriteStrobeN,
  input wire logic [3:0] decoderRegAddress,
  input wire logic [7:0] decoderByteBus,
  input wire logic byteBusOe,
  // Bench controls
  input wire logic drain,
  input wire logic ackHold,
  // Back to the port
  output logic fifoSpaceRequest,
  output logic targetAck
);
  timeunit 1ns;
  timeprecision 1ps;
  logic prevN = 1'b1;
  logic junk = 1'b0;
  int used = 0;
  logic [7:0] got[$];
  logic [3:0] gotAddr = 4'h0;
  // Request high while the FIFO has room
  assign fifoSpaceRequest = used < DEPTH;
  // Ready only while selected; a toggling level otherwise
  assign targetAck = portSelectN ? junk : !ackHold;
  // Slot reserved as the strobe falls, so request drops in time
  // for the port's decision on the following byte
  always @(posedge clock)
  begin
    prevN <= byteWriteStrobeN;
    junk <= !junk;
    if (drain)
      used <= 0;
    else if (prevN && !byteWriteStrobeN && !portSelectN)
      used <= used + 1;
    // Byte taken as the strobe rises under select
    if (!prevN && byteWriteStrobeN && !portSelectN)
    begin
      got.push_back(byteBusOe ? decoderByteBus : ~decoderByteBus);
      gotAddr <= decoderRegAddress;
    end
  end
endmodule : dpbw_decoder_model

// ---- dv/dpbw_burst_writer_test.sv ----
module dpbw_burst_writer_test;
  timeunit 1ns;
  timeprecision 1ps;
  // ----------------------------------------
  // Signals
  // ----------------------------------------
  logic clock = 0, rst = 1, pinMode = 1, rdyEn = 0, pause = 0;
  logic hostPend = 0, hostAct = 0, fifoValid = 0, drain = 0, ackHold = 0;
  logic [7:0] fifoByte = 8'h00;
  logic [3:0] regAddr = 4'hB;
  logic busBusy, fifoPop, req, ack, addrOe, byteBusOe, selN, wrN;
  logic [3:0] addr;
  logic [7:0] bus;
  logic [7:0] q[$];
  int num_errors = 0, compares = 0, cyc = 0, wLow = 0, wLast = 0, n;
  logic [19:0] rows[4] = '{20'hB5A05, 20'h3A505, 20'h60005, 20'hFFF05};
  dpbw_burst_writer dut (.clock(clock), .rst(rst), .requestPinMode(pinMode),
    .readyCheckEn(rdyEn), .transferPauseBit(pause),
    .fifoRegAddr(regAddr), .hostPending(hostPend),
    .hostCycleActive(hostAct), .busBusy(busBusy), .fifoValid(fifoValid),
    .fifoByte(fifoByte), .fifoPop(fifoPop), .sharedPinIn(req),
    .targetAckIn(ack), .decoderRegAddress(addr), .addrOe(addrOe),
    .decoderByteBus(bus), .byteBusOe(byteBusOe), .portSelectN(selN),
    .byteWriteStrobeN(wrN));
  dpbw_decoder_model dec (.clock(clock), .portSelectN(selN),
    .byteWriteStrobeN(wrN), .decoderRegAddress(addr),
    .decoderByteBus(bus), .byteBusOe(byteBusOe), .drain(drain),
    .ackHold(ackHold), .fifoSpaceRequest(req), .targetAck(ack));
  // ----------------------------------------
  // Clock, port FIFO, strobe width, timeout
  // ----------------------------------------
  always #2 clock = ~clock;
  always @(posedge clock)
  begin
    if (fifoPop && q.size() != 0)
      void'(q.pop_front());
    fifoValid <= q.size() != 0;
    fifoByte <= q.size() != 0 ? q[0] : 8'h00;
    wLow <= wrN ? 0 : wLow + 1;
    if (!wrN)
      wLast <= wLow + 1;
    cyc++;
    if (cyc > 20000)
    begin
      num_errors++;
      test_done();
    end
  end
  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  task automatic chk(string name, logic [7:0] exp, logic [7:0] got);
    compares++;
    if (exp !== got)
    begin
      num_errors++;
      $display("[FAIL] %s exp %h got %h", name, exp, got);
    end
  endtask : chk
  task automatic cycles(int k);
    repeat (k) @(posedge clock);
  endtask : cycles
  task automatic waitCap(int k);
    int m;
    m = dec.got.size();
    for (int i = 0; i < k && dec.got.size() == m; i++)
      @(posedge clock);
    // One more edge so the model's captured address has settled
    @(posedge clock);
  endtask : waitCap
  task automatic emptyDec();
    drain <= 1;
    cycles(1);
    drain <= 0;
    n = dec.got.size();
  endtask : emptyDec
  task automatic test_done();
    $display("compares %0d errors %0d", compares, num_errors);
    if (num_errors == 0 && compares > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : test_done
  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial
  begin
    cycles(16);
    rst <= 0;
    cycles(2);
    foreach (rows[i])
    begin
      emptyDec();
      regAddr <= rows[i][19:16];
      q.push_back(rows[i][15:8]);
      waitCap(60);
      chk("byte", rows[i][15:8], dec.got[n]);
      chk("addr", {4'h0, rows[i][19:16]}, {4'h0, dec.gotAddr});
      chk("width", rows[i][7:0], wLast[7:0]);
    end
    $display("test rows done");
    // Reset cutting into a byte: port falls idle, byte is lost
    emptyDec();
    q.push_back(8'h66);
    for (int i = 0; i < 60 && wrN; i++)
      @(posedge clock);
    rst <= 1;
    cycles(2);
    rst <= 0;
    cycles(2);
    chk("select", 8'h01, {7'h0, selN});
    chk("strobe", 8'h01, {7'h0, wrN});
    chk("oe", 8'h00, {6'h0, addrOe, byteBusOe});
    chk("busy", 8'h00, {7'h0, busBusy});
    chk("cut", n[7:0], 8'(dec.got.size()));
    $display("test reset done");
    emptyDec();
    pause <= 1;
    q.push_back(8'h3C);
    cycles(40);
    chk("paused", n[7:0], 8'(dec.got.size()));
    pause <= 0;
    waitCap(60);
    chk("resumed", 8'h3C, dec.got[n]);
    $display("test pause done");
    emptyDec();
    for (int i = 0; i < 4; i++)
      q.push_back(8'h10 + 8'(i));
    cycles(12);
    // Address input moves mid-burst; the burst keeps its own
    regAddr <= 4'h7;
    cycles(88);
    chk("full", 8'(n + 3), 8'(dec.got.size()));
    chk("left", 8'h01, 8'(q.size()));
    chk("held addr", 8'h0F, {4'h0, dec.gotAddr});
    emptyDec();
    waitCap(60);
    chk("after", 8'h13, dec.got[n]);
    chk("new addr", 8'h07, {4'h0, dec.gotAddr});
    $display("test request done");
    cycles(4);
    emptyDec();
    q = '{8'h21, 8'h22, 8'h23};
    for (int i = 0; i < 60 && wrN; i++)
      @(posedge clock);
    hostPend <= 1;
    chk("busy on", 8'h01, {7'h0, busBusy});
    cycles(40);
    chk("one byte", 8'(n + 1), 8'(dec.got.size()));
    chk("released", 8'h01, {7'h0, selN});
    // Host cycle now owns the link: no burst may start
    hostAct <= 1;
    hostPend <= 0;
    cycles(20);
    chk("bus held", 8'(n + 1), 8'(dec.got.size()));
    hostAct <= 0;
    cycles(40);
    chk("rest", 8'h23, dec.got[n + 2]);
    $display("test host done");
    emptyDec();
    pinMode <= 0;
    q.push_back(8'h44);
    cycles(40);
    chk("no mode", n[7:0], 8'(dec.got.size()));
    pinMode <= 1;
    waitCap(60);
    chk("mode on", 8'h44, dec.got[n]);
    rdyEn <= 1;
    ackHold <= 1;
    emptyDec();
    q.push_back(8'h55);
    for (int i = 0; i < 60 && wrN; i++)
      @(posedge clock);
    cycles(12);
    chk("wait", 8'h00, {7'h0, wrN});
    ackHold <= 0;
    waitCap(8);
    chk("ready", 8'h55, dec.got[n]);
    $display("test ready done");
    test_done();
  end
endmodule : dpbw_burst_writer_test
